// >>> wdt_pkg.sv
package wdt_pkg;

  // register map, special-function addresses
  localparam logic [7:0] SERVICE_KEY_ADDR   = 8'hA6;
  localparam logic [7:0] PERIOD_SELECT_ADDR = 8'hA7;

  // key sequence
  localparam logic [7:0] KEY_FIRST  = 8'h1E;
  localparam logic [7:0] KEY_SECOND = 8'hE1;

  // period register layout
  localparam int          PERIOD_SEL_LSB   = 0;
  localparam int          PERIOD_SEL_W     = 3;
  localparam logic [2:0]  PERIOD_SEL_RST   = 3'h0;

  // counter geometry
  localparam int          CORE_W           = 14;
  localparam logic [13:0] CORE_TERMINAL    = 14'h3FFF;
  localparam int          PRESCALE_W       = 7;

  // reset pulse on overflow, in peripheral clock periods
  localparam int          RST_PULSE_CYCLES = 96;
  localparam int          RST_CNT_W        = 7;

  // unmapped reads
  localparam logic [7:0]  READ_DEFAULT     = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       idle;        // oscillator runs, cpu halted
    logic       power_down;  // oscillator halted
    logic       ext_int_n;   // level external interrupt pin, active low
  } power_ctl_t;

endpackage

// >>> wdt_pulse_gen.sv
`timescale 1ns/1ps

module wdt_pulse_gen #(
  parameter int LEN = wdt_pkg::RST_PULSE_CYCLES,
  parameter int W   = wdt_pkg::RST_CNT_W
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // trigger and pulse
  input  wire logic start_i,
  output logic      pulse_o
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         act;
  } pulse_state_t;

  pulse_state_t state_ff;
  pulse_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (state_ff.act) begin
      if (state_ff.cnt == W'(LEN - 1)) begin
        nxt_state.act = 1'b0;
        nxt_state.cnt = '0;
      end else begin
        nxt_state.cnt = state_ff.cnt + W'(1);
      end
    end else if (start_i) begin
      nxt_state.act = 1'b1;
      nxt_state.cnt = '0;
    end
  end

  // pulse generator must survive the reset it causes, so only sys reset clears it
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pulse_o = state_ff.act;

endmodule // wdt_pulse_gen

// >>> hardware_watchdog_timer.sv
`timescale 1ns/1ps

// Functional notes
// - the core is a 14-bit up-counter enabled and restarted through a service register.
// - after any reset the watchdog is off and does not count until keyed.
// - writing 1E then E1 to the service register at A6 enables the watchdog.
// - once enabled the counter advances once per machine cycle while the oscillator runs.
// - once enabled no write can disable it; only a reset or its own overflow does.
// - the core overflows at 3FFF and that overflow resets the device.
// - an overflow drives an active-high reset pulse on the reset pin.
// - the overflow reset pulse lasts 96 peripheral clock periods.
// - the service register is write-only and the counter is not software visible.
// - a 7-bit prescaler extends the time-out, selected by bits 2..0 of the period register.
// - the period register is set before enabling and frozen after until reset.
// - in power-down the counter holds its value.
// - after leaving power-down by a level interrupt, counting resumes once the line is high.
// - in idle the enabled watchdog keeps counting and may reset the device.
module hardware_watchdog_timer (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  // register port
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [7:0]         rdata_o,
  // machine cycle strobe, same clock domain
  input  wire logic               mcycle_i,
  // power state, pins
  input  wire logic               idle_i,
  input  wire logic               power_down_i,
  input  wire logic               ext_int_n_i,
  // reset pin drive and status
  output logic                    wdt_rst_o,
  output logic                    wdt_enabled_o
);
  import wdt_pkg::*;

  localparam int TOT_W = CORE_W + PRESCALE_W;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_HOLD,
    ST_WAKE
  } run_state_t;

  typedef struct packed {
    run_state_t                 run;
    logic                       key_armed;
    logic [TOT_W-1:0]           count;
    logic [PERIOD_SEL_W-1:0]    period_sel;
    logic [7:0]                 rdata;
    logic                       enabled;
    logic                       ovf;
    logic [1:0]                 idle_sync;
    logic [1:0]                 pd_sync;
    logic [1:0]                 int_sync;
  } wdt_state_t;

  wdt_state_t state_ff;
  wdt_state_t nxt_state;
  reg_req_t   req;
  power_ctl_t pwr;
  logic       pulse;

  // terminal value for a select code; higher codes take prescaler bits
  function automatic logic [TOT_W-1:0] terminal_of(input logic [PERIOD_SEL_W-1:0] sel);
    logic [TOT_W-1:0] t;
    t = {{PRESCALE_W{1'b0}}, CORE_TERMINAL};
    for (int i = 0; i < (1 << PERIOD_SEL_W); i++) begin
      if (PERIOD_SEL_W'(i) < sel) begin
        t = {t[TOT_W-2:0], 1'b1};
      end
    end
    return t;
  endfunction

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // pins pass two flops; only stage [1] is read
  assign pwr = '{idle: state_ff.idle_sync[1],
                 power_down: state_ff.pd_sync[1],
                 ext_int_n: state_ff.int_sync[1]};

  always_comb begin
    logic key_hit;
    logic tick;
    key_hit = 1'b0;
    tick    = 1'b0;
    nxt_state = state_ff;
    nxt_state.ovf       = 1'b0;
    nxt_state.idle_sync = {state_ff.idle_sync[0], idle_i};
    nxt_state.pd_sync   = {state_ff.pd_sync[0], power_down_i};
    nxt_state.int_sync  = {state_ff.int_sync[0], ext_int_n_i};

    // register writes
    if (req.wr && req.addr == SERVICE_KEY_ADDR) begin
      key_hit = state_ff.key_armed && (req.wdata == KEY_SECOND);
      nxt_state.key_armed = (req.wdata == KEY_FIRST);
    end else if (req.wr && req.addr == PERIOD_SELECT_ADDR) begin
      if (!state_ff.enabled) begin
        nxt_state.period_sel = req.wdata[PERIOD_SEL_LSB +: PERIOD_SEL_W];
      end
    end

    // reads: service key and counter are not visible
    nxt_state.rdata = READ_DEFAULT;
    if (req.rd && req.addr == PERIOD_SELECT_ADDR) begin
      nxt_state.rdata = {{(8 - PERIOD_SEL_W){1'b0}}, state_ff.period_sel};
    end

    // idle keeps the oscillator running, so it does not stop counting
    tick = mcycle_i;

    case (state_ff.run)
      ST_OFF: begin
        if (key_hit) begin
          nxt_state.run     = ST_RUN;
          nxt_state.enabled = 1'b1;
          nxt_state.count   = '0;
        end
      end
      ST_RUN: begin
        if (pwr.power_down) begin
          nxt_state.run = ST_HOLD;
        end else if (key_hit) begin
          nxt_state.count = '0;
        end else if (tick) begin
          if (state_ff.count == terminal_of(state_ff.period_sel)) begin
            nxt_state.ovf = 1'b1;
          end else begin
            nxt_state.count = state_ff.count + TOT_W'(1);
          end
        end
      end
      ST_HOLD: begin
        // count frozen while oscillator is halted
        if (!pwr.power_down) begin
          nxt_state.run = pwr.ext_int_n ? ST_RUN : ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (pwr.ext_int_n) begin
          nxt_state.run = ST_RUN;
        end
        if (key_hit) begin
          nxt_state.count = '0;
        end
      end
      default: begin
        nxt_state.run = ST_OFF;
      end
    endcase

    // overflow resets the device, which disables the watchdog again
    if (state_ff.ovf || pulse) begin
      nxt_state.run        = ST_OFF;
      nxt_state.enabled    = 1'b0;
      nxt_state.count      = '0;
      nxt_state.key_armed  = 1'b0;
      nxt_state.period_sel = PERIOD_SEL_RST;
      nxt_state.ovf        = 1'b0;
    end
  end

  // nothing but reset or overflow clears enabled
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= '{run: ST_OFF, period_sel: PERIOD_SEL_RST, rdata: READ_DEFAULT,
                    int_sync: 2'b11, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  wdt_pulse_gen #(
    .LEN (RST_PULSE_CYCLES),
    .W   (RST_CNT_W)
  ) u_pulse (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (state_ff.ovf),
    .pulse_o   (pulse)
  );

  assign rdata_o       = state_ff.rdata;
  assign wdt_rst_o     = pulse;
  assign wdt_enabled_o = state_ff.enabled;

endmodule // hardware_watchdog_timer

// >>> wdt_monitor.sv
`timescale 1ns/1ps
module wdt_monitor (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // status
  input wire logic       power_down_i,
  input wire logic       wdt_rst_o,
  input wire logic       wdt_enabled_o
);
  import wdt_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] hi_ff;
  wire key1 = wr_i && addr_i == SERVICE_KEY_ADDR && wdata_i == KEY_FIRST;
  wire key2 = wr_i && addr_i == SERVICE_KEY_ADDR && wdata_i == KEY_SECOND;
  // length of the current reset pulse so far
  always_ff @(posedge clk_sys_i) hi_ff <= wdt_rst_o ? hi_ff + 8'h01 : 8'h00;
  a_read_hidden: assert property (
    rd_i && addr_i != PERIOD_SELECT_ADDR |=> rdata_o == 8'h00) else $error("hidden read");
  a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("stale read");
  a_key_enable: assert property (key1 ##1 key2 |=> wdt_enabled_o) else $error("key");
  a_no_disable: assert property (
    $fell(wdt_enabled_o) |-> $rose(wdt_rst_o)) else $error("disabled without overflow");
  a_off_at_start: assert property ($fell(sys_rst_i) |-> !wdt_enabled_o) else $error("on");
  a_pulse_len: assert property ($fell(wdt_rst_o) |-> hi_ff == 8'h60) else $error("len");
  a_pulse_cause: assert property (
    $rose(wdt_rst_o) |-> $past(wdt_enabled_o, 2) && !wdt_enabled_o) else $error("cause");
  a_halt_hold: assert property (
    power_down_i [*5] |-> !$fell(wdt_enabled_o)) else $error("counted in power-down");
  cover property (key1 ##1 key2);
  cover property ($rose(wdt_rst_o));
  cover property (power_down_i && wdt_enabled_o);
endmodule // wdt_monitor
bind hardware_watchdog_timer wdt_monitor u_mon (.clk_sys_i, .sys_rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .power_down_i, .wdt_rst_o, .wdt_enabled_o);

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  import wdt_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       mcycle_i = 1'b0;
  logic       idle_i = 1'b0;
  logic       power_down_i = 1'b0;
  logic       ext_int_n_i = 1'b1;
  logic [7:0] rdata_o;
  logic       wdt_rst_o;
  logic       wdt_enabled_o;
  logic [7:0] d;
  int         bad_count = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n;
  hardware_watchdog_timer DUT (.clk_sys_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .mcycle_i, .idle_i, .power_down_i, .ext_int_n_i, .wdt_rst_o, .wdt_enabled_o);
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  function automatic logic [7:0] sel_rd(input logic [2:0] s);
    return {5'h00, s};
  endfunction
  function automatic int ovf_len(input int s);
    return 1 << (CORE_W + s);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // run needs about 81000 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 `CHK(nm, e, rdata_o)
    @(posedge clk_sys_i);
  endtask
  task automatic mc(input int k);
    mcycle_i <= 1'b1;
    repeat (k) @(posedge clk_sys_i);
    mcycle_i <= 1'b0;
  endtask
  task automatic service();
    wr(SERVICE_KEY_ADDR, KEY_FIRST);
    wr(SERVICE_KEY_ADDR, KEY_SECOND);
  endtask
  initial begin
    void'($urandom(32'hB6ECC61E));
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 `CHK("enabled", 1'b0, wdt_enabled_o)
    d = 8'($urandom_range(7));
    wr(PERIOD_SELECT_ADDR, d);
    rd(PERIOD_SELECT_ADDR, sel_rd(d[2:0]), "period");
    rd(SERVICE_KEY_ADDR, 8'h00, "key reg");
    rd(8'($urandom_range(8'h10, 8'h90)), READ_DEFAULT, "unmapped");
    $display("test registers done");
    // a foreign value between the two keys must disarm
    repeat (3) begin
      wr(SERVICE_KEY_ADDR, KEY_FIRST);
      wr(SERVICE_KEY_ADDR, 8'($urandom_range(8'h20, 8'hD0)));
      wr(SERVICE_KEY_ADDR, KEY_SECOND);
      `CHK("bad key", 1'b0, wdt_enabled_o)
    end
    wr(SERVICE_KEY_ADDR, KEY_FIRST);
    wr(PERIOD_SELECT_ADDR, 8'h00);
    wr(SERVICE_KEY_ADDR, KEY_SECOND);
    `CHK("enable", 1'b1, wdt_enabled_o)
    wr(PERIOD_SELECT_ADDR, 8'h05);
    rd(PERIOD_SELECT_ADDR, sel_rd(3'h0), "frozen");
    wr(SERVICE_KEY_ADDR, 8'h00);
    wr(SERVICE_KEY_ADDR, 8'($urandom));
    `CHK("stay on", 1'b1, wdt_enabled_o)
    $display("test keys done");
    power_down_i <= 1'b1;
    mc(20000);
    `CHK("halted", 1'b1, wdt_enabled_o)
    @(posedge clk_sys_i);
    power_down_i <= 1'b0;
    ext_int_n_i  <= 1'b0;
    mc(20000);
    #1 `CHK("wake wait", 1'b1, wdt_enabled_o)
    ext_int_n_i <= 1'b1;
    $display("test power-down done");
    idle_i <= 1'b1;
    service();
    mc(12000);
    service();
    mc(12000);
    service();
    #1 `CHK("serviced", 1'b1, wdt_enabled_o)
    mc(ovf_len(0) - 1);
    repeat (2) @(posedge clk_sys_i);
    #1 `CHK("before ovf", 1'b1, wdt_enabled_o)
    mc(1);
    @(posedge clk_sys_i);
    #1 `CHK("ovf", 1'b0, wdt_enabled_o)
    n = 0;
    while (wdt_rst_o !== 1'b1 && n < 5) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    `CHK("rise delay", 0, n)
    n = 0;
    while (wdt_rst_o === 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    `CHK("pulse len", RST_PULSE_CYCLES, n)
    $display("test overflow done");
    give_verdict();
  end
endmodule // tb_top
